// File: shared/gdi_pkg.sv
// Constants, carriers and state encodings for the instrument-side GPIB device interface.
// Assumes a single 250 MHz clock, synchronous reset, and a classic Wishbone master.
// Operation
// - Full source and acceptor handshake, basic talker with serial poll, basic listener.
// - No parallel poll answer and no controller function; never drives ATN.
// - Service request, remote/local with lockout, device clear and trigger via GET.
// - Interface clear halts all transfers but leaves both buffers intact.
// - REN true puts the device remote until GTL, REN false or local key.
// - In local state every received data byte is discarded.
// - Remote ignores all keys but local; lockout ignores every key.
// - SPE enters serial poll mode, talking sends the status byte; SPD or IFC leave.
// - Polled status byte carries RQS in bit 6, cleared once that byte is sent.
// - DCL empties both buffers and resets parser, execution and response logic.
// - Device clear keeps settings and status bits; only message available drops.
// - SDC acts like DCL only while addressed as listener, else ignored.
// - GTL puts the device into local state and enables the front panel, only while addressed as listener.
// - LLO locks the panel whenever REN is true, remote or local; GTL, REN false or reset release it.
// - Input buffer holds 255 bytes; overflowing it raises an error flag.
// - Output buffer holds 255 bytes; only reset, DCL or SDC empty the buffers.
// - Parser marks leading asterisk as common header and trailing question mark as query.
// - Parser needs one or more spaces between header and data.
// - Data items split at commas, with spaces tolerated around each comma.
// - Several commands per line, back to back or split by semicolon, comma, space.
// - ATN wins over a device transfer; the transfer is abandoned and its byte stays queued.
// - Status bit 4 is set while the output buffer holds data, clear when empty.
package gdi_pkg;
	localparam int         DEPTH       = 255;
	localparam int         PW          = 8;
	localparam int         ADDR_W      = 5;

	localparam logic [7:0] REG_CONFIG  = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_STB     = 8'h08;
	localparam logic [7:0] REG_INDATA  = 8'h0C;
	localparam logic [7:0] REG_OUTDATA = 8'h10;
	localparam logic [7:0] REG_PANEL   = 8'h14;

	localparam int CFG_TONLY   = 5;
	localparam int ST_REMOTE   = 0;
	localparam int ST_LOCKOUT  = 1;
	localparam int ST_LISTEN   = 2;
	localparam int ST_TALK     = 3;
	localparam int ST_SPMODE   = 4;
	localparam int ST_INERR    = 5;
	localparam int ST_RQS      = 6;
	localparam int ST_OUTFULL  = 7;
	localparam int ST_INCNT    = 8;
	localparam int ST_OUTCNT   = 16;
	localparam int STB_DSB     = 3;
	localparam int STB_MAV     = 4;
	localparam int STB_ESB     = 5;
	localparam int STB_RQS     = 6;
	localparam int IND_CLS     = 8;
	localparam int IND_VALID   = 16;
	localparam int PNL_LOCAL   = 0;
	localparam int PNL_OTHER   = 1;

	localparam logic [6:0] CMD_GTL     = 7'h01;
	localparam logic [6:0] CMD_SDC     = 7'h04;
	localparam logic [6:0] CMD_GET     = 7'h08;
	localparam logic [6:0] CMD_LLO     = 7'h11;
	localparam logic [6:0] CMD_DCL     = 7'h14;
	localparam logic [6:0] CMD_SPE     = 7'h18;
	localparam logic [6:0] CMD_SPD     = 7'h19;
	localparam logic [6:0] CMD_UNL     = 7'h3F;
	localparam logic [6:0] CMD_UNT     = 7'h5F;
	localparam logic [1:0] GRP_LISTEN  = 2'h1;
	localparam logic [1:0] GRP_TALK    = 2'h2;

	localparam logic [7:0] CH_STAR     = 8'h2A;
	localparam logic [7:0] CH_QUERY    = 8'h3F;
	localparam logic [7:0] CH_SPACE    = 8'h20;
	localparam logic [7:0] CH_COMMA    = 8'h2C;
	localparam logic [7:0] CH_SEMI     = 8'h3B;
	localparam logic [7:0] CH_LF       = 8'h0A;
	localparam logic [7:0] CH_CR       = 8'h0D;

	localparam logic [3:0] CLS_HDR     = 4'h1;
	localparam logic [3:0] CLS_COMMON  = 4'h2;
	localparam logic [3:0] CLS_QUERY   = 4'h3;
	localparam logic [3:0] CLS_SPACE   = 4'h4;
	localparam logic [3:0] CLS_DATA    = 4'h5;
	localparam logic [3:0] CLS_ITEMSEP = 4'h6;
	localparam logic [3:0] CLS_CMDSEP  = 4'h7;
	localparam logic [3:0] CLS_END     = 4'h8;
	localparam logic [3:0] CLS_OTHER   = 4'h9;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} gdi_wbReq_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} gdi_wbRsp_t;

	// Electrical levels of the bus lines; every line is true when low.
	typedef struct packed {
		logic [7:0] dio;
		logic       dav;
		logic       nrfd;
		logic       ndac;
		logic       eoi;
		logic       atn;
		logic       ifc;
		logic       ren;
	} gdi_busIn_t;

	typedef struct packed {
		logic [7:0] dio;
		logic       dioOeN;
		logic       dav;
		logic       davOeN;
		logic       nrfd;
		logic       nrfdOeN;
		logic       ndac;
		logic       ndacOeN;
		logic       eoi;
		logic       eoiOeN;
		logic       srq;
		logic       srqOeN;
	} gdi_busOut_t;

	localparam gdi_busIn_t  BUS_IN_IDLE  = '1;
	localparam gdi_busOut_t BUS_OUT_IDLE = '{dio: 8'hFF, dioOeN: 1'b1, dav: 1'b1, davOeN: 1'b1,
		nrfd: 1'b0, nrfdOeN: 1'b1, ndac: 1'b0, ndacOeN: 1'b1, eoi: 1'b1, eoiOeN: 1'b1,
		srq: 1'b0, srqOeN: 1'b1};

	typedef enum logic [2:0] {
		SRC_IDLE = 3'b001,
		SRC_WAIT = 3'b010,
		SRC_DAV  = 3'b100
	} gdi_src_t;

	typedef enum logic [2:0] {
		ACC_IDLE  = 3'b001,
		ACC_READY = 3'b010,
		ACC_HOLD  = 3'b100
	} gdi_acc_t;
endpackage : gdi_pkg

// File: core/gdi_core.sv
// GPIB device interface: bus handshakes, addressing, remote/local, buffers and parser tags.
// Assumes bus pins arrive asynchronously and a classic Wishbone master owns the registers.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module gdi_core #(
	parameter int DEPTH = gdi_pkg::DEPTH
) (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire gdi_pkg::gdi_wbReq_t  wbReq,
	output gdi_pkg::gdi_wbRsp_t       wbRsp,
	input  wire gdi_pkg::gdi_busIn_t  busIn,
	output gdi_pkg::gdi_busOut_t      busOut,
	output logic                      trigger,
	output logic                      devClear
);
	import gdi_pkg::*;

	typedef struct packed {
		logic [3:0] cls;
		logic       hdr;
		logic       dat;
		logic       sp;
	} gdi_parse_t;

	typedef struct packed {
		gdi_busIn_t              sync1;
		gdi_busIn_t              sync2;
		logic                    renPrev;
		gdi_busOut_t             bus;
		gdi_src_t                src;
		gdi_acc_t                acc;
		logic [ADDR_W-1:0]       cfgAddr;
		logic                    cfgTonly;
		logic                    remote;
		logic                    lockout;
		logic                    listen;
		logic                    talk;
		logic                    spMode;
		logic                    rqs;
		logic                    esb;
		logic                    dsb;
		logic                    inErr;
		logic                    keyTaken;
		logic [DEPTH-1:0][7:0]   inMem;
		logic [DEPTH-1:0][7:0]   outMem;
		logic [PW-1:0]           inWr;
		logic [PW-1:0]           inRd;
		logic [PW-1:0]           inCnt;
		logic [PW-1:0]           outWr;
		logic [PW-1:0]           outRd;
		logic [PW-1:0]           outCnt;
		logic                    pHdr;
		logic                    pDat;
		logic                    pSp;
		logic                    wbAck;
		logic [31:0]             wbDat;
		logic                    trigger;
		logic                    devClear;
	} gdi_state_t;

	gdi_state_t s;
	gdi_state_t n;

	logic       atnT;
	logic       ifcT;
	logic       renT;
	logic       davT;
	logic       nrfdT;
	logic       ndacT;
	logic [7:0] rxByte;
	logic [6:0] cmd;
	logic       partake;
	logic       talkOk;
	logic       avail;
	logic [7:0] stbByte;
	logic       wbHit;
	logic       wbWr;
	logic       inPush;
	logic       inPop;
	logic       outPush;
	logic       outPop;
	logic       clearBufs;
	logic       errSet;
	logic       errClr;
	logic       rqsSet;
	logic       rqsClr;
	gdi_parse_t pr;

	function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : ptrInc

	function automatic logic [PW-1:0] cntStep(input logic [PW-1:0] c, input logic up,
		input logic dn);
		logic [PW-1:0] r;
		r = c;
		if (up && !dn) begin
			r = PW'(c + 1'b1);
		end else if (dn && !up) begin
			r = PW'(c - 1'b1);
		end
		return r;
	endfunction : cntStep

	// Tags one popped byte with its syntactic role; hdr, dat and sp carry the context.
	function automatic gdi_parse_t classify(input logic [7:0] b, input logic hdr,
		input logic dat, input logic sp);
		gdi_parse_t r;
		logic       letter;
		letter = (b >= 8'h41 && b <= 8'h5A) || (b >= 8'h61 && b <= 8'h7A);
		r = '{cls: CLS_OTHER, hdr: hdr, dat: dat, sp: 1'b0};
		if (b == CH_STAR) begin
			r = '{cls: CLS_COMMON, hdr: 1'b1, dat: 1'b0, sp: 1'b0};
		end else if (b == CH_QUERY) begin
			if (hdr) begin
				r = '{cls: CLS_QUERY, hdr: 1'b0, dat: 1'b0, sp: 1'b0};
			end
		end else if (b == CH_SPACE) begin
			r = '{cls: CLS_SPACE, hdr: 1'b0, dat: dat, sp: 1'b1};
		end else if (b == CH_COMMA) begin
			if (dat) begin
				r = '{cls: CLS_ITEMSEP, hdr: 1'b0, dat: 1'b1, sp: 1'b0};
			end else begin
				r = '{cls: CLS_CMDSEP, hdr: 1'b0, dat: 1'b0, sp: 1'b0};
			end
		end else if (b == CH_SEMI) begin
			r = '{cls: CLS_CMDSEP, hdr: 1'b0, dat: 1'b0, sp: 1'b0};
		end else if (b == CH_LF || b == CH_CR) begin
			r = '{cls: CLS_END, hdr: 1'b0, dat: 1'b0, sp: 1'b0};
		end else if (b > CH_SPACE) begin
			if (hdr && !sp) begin
				r = '{cls: CLS_HDR, hdr: 1'b1, dat: 1'b0, sp: 1'b0};
			end else if (letter && (!dat || sp)) begin
				r = '{cls: CLS_HDR, hdr: 1'b1, dat: 1'b0, sp: 1'b0};
			end else begin
				r = '{cls: CLS_DATA, hdr: 1'b0, dat: 1'b1, sp: 1'b0};
			end
		end
		return r;
	endfunction : classify

	assign atnT   = ~s.sync2.atn;
	assign ifcT   = ~s.sync2.ifc;
	assign renT   = ~s.sync2.ren;
	assign davT   = ~s.sync2.dav;
	assign nrfdT  = ~s.sync2.nrfd;
	assign ndacT  = ~s.sync2.ndac;
	assign rxByte = ~s.sync2.dio;
	assign cmd    = rxByte[6:0];

	always_comb begin
		n         = s;
		inPush    = 1'b0;
		inPop     = 1'b0;
		outPush   = 1'b0;
		outPop    = 1'b0;
		clearBufs = 1'b0;
		errSet    = 1'b0;
		errClr    = 1'b0;
		rqsSet    = 1'b0;
		rqsClr    = 1'b0;
		pr        = '{cls: CLS_OTHER, hdr: s.pHdr, dat: s.pDat, sp: s.pSp};
		stbByte   = '0;
		stbByte[STB_RQS] = s.rqs;
		stbByte[STB_ESB] = s.esb;
		stbByte[STB_MAV] = (s.outCnt != '0);
		stbByte[STB_DSB] = s.dsb;
		partake   = !ifcT && (atnT || s.listen);
		talkOk    = s.talk && !atnT && !ifcT;
		avail     = s.spMode || (s.outCnt != '0);
		wbHit     = wbReq.cyc && wbReq.stb && !s.wbAck;
		wbWr      = wbHit && wbReq.we && wbReq.sel[0];

		n.sync1    = busIn;
		n.sync2    = s.sync1;
		n.renPrev  = renT;
		n.trigger  = 1'b0;
		n.devClear = 1'b0;

		if (!renT) begin
			n.remote  = 1'b0;
			n.lockout = 1'b0;
		end else if (!s.renPrev) begin
			n.remote = 1'b1;
		end

		if (ifcT) begin
			n.talk   = 1'b0;
			n.listen = 1'b0;
			n.spMode = 1'b0;
		end else if (s.cfgTonly) begin
			n.talk   = 1'b1;
			n.listen = 1'b0;
		end

		// Acceptor handshake; the device takes part while ATN is true or it is listener, never while IFC is true.
		case (s.acc)
			ACC_IDLE: begin
				if (partake) begin
					n.acc = ACC_READY;
				end
			end
			ACC_READY: begin
				if (!partake) begin
					n.acc = ACC_IDLE;
				end else if (davT) begin
					n.acc = ACC_HOLD;
					if (atnT) begin
						if (cmd == CMD_UNL) begin
							n.listen = 1'b0;
						end else if (cmd == CMD_UNT) begin
							n.talk = s.cfgTonly;
						end else if (cmd[6:5] == GRP_LISTEN) begin
							if (cmd[4:0] == s.cfgAddr && !s.cfgTonly) begin
								n.listen = 1'b1;
								n.talk   = 1'b0;
								n.remote = s.remote || renT;
							end
						end else if (cmd[6:5] == GRP_TALK) begin
							if (!s.cfgTonly) begin
								n.talk = (cmd[4:0] == s.cfgAddr);
								if (cmd[4:0] == s.cfgAddr) begin
									n.listen = 1'b0;
								end
							end
						end else begin
							case (cmd)
								CMD_SPE: n.spMode = 1'b1;
								CMD_SPD: n.spMode = 1'b0;
								CMD_DCL: clearBufs = 1'b1;
								CMD_SDC: clearBufs = s.listen;
								CMD_GET: n.trigger = s.listen;
								CMD_LLO: n.lockout = renT;
								CMD_GTL: begin
									if (s.listen) begin
										n.remote  = 1'b0;
										n.lockout = 1'b0;
									end
								end
								default: begin
								end
							endcase
						end
					end else if (s.listen && s.remote) begin
						if (s.inCnt == PW'(DEPTH)) begin
							errSet = 1'b1;
						end else begin
							inPush = 1'b1;
						end
					end
				end
			end
			ACC_HOLD: begin
				if (!partake) begin
					n.acc = ACC_IDLE;
				end else if (!davT) begin
					n.acc = ACC_READY;
				end
			end
			default: n.acc = ACC_IDLE;
		endcase
		n.bus.ndac    = 1'b0;
		n.bus.nrfd    = 1'b0;
		n.bus.ndacOeN = (n.acc != ACC_READY);
		n.bus.nrfdOeN = (n.acc != ACC_HOLD);

		// Source handshake; ATN or IFC abandons the byte in flight.
		case (s.src)
			SRC_IDLE: begin
				if (talkOk && avail) begin
					n.src        = SRC_WAIT;
					n.bus.dio    = ~(s.spMode ? stbByte : s.outMem[s.outRd]);
					n.bus.dioOeN = 1'b0;
					n.bus.dav    = 1'b1;
					n.bus.davOeN = 1'b0;
					n.bus.eoi    = s.spMode || (s.outCnt != PW'(1));
					n.bus.eoiOeN = 1'b0;
				end else begin
					n.bus.dioOeN = 1'b1;
					n.bus.davOeN = 1'b1;
					n.bus.eoiOeN = 1'b1;
				end
			end
			SRC_WAIT: begin
				if (!talkOk) begin
					n.src = SRC_IDLE;
				end else if (!nrfdT && ndacT) begin
					n.src     = SRC_DAV;
					n.bus.dav = 1'b0;
				end
			end
			SRC_DAV: begin
				if (!talkOk) begin
					n.src = SRC_IDLE;
				end else if (!ndacT) begin
					n.src     = SRC_IDLE;
					n.bus.dav = 1'b1;
					if (s.spMode) begin
						rqsClr = 1'b1;
					end else begin
						outPop = 1'b1;
					end
				end
			end
			default: n.src = SRC_IDLE;
		endcase
		if (n.src == SRC_IDLE && s.src != SRC_IDLE && !talkOk) begin
			n.bus.dioOeN = 1'b1;
			n.bus.davOeN = 1'b1;
			n.bus.eoiOeN = 1'b1;
			n.bus.dav    = 1'b1;
		end

		// Register slave; every access is answered one cycle later.
		n.wbAck = wbHit;
		n.wbDat = '0;
		if (wbHit) begin
			case (wbReq.adr)
				REG_CONFIG: begin
					n.wbDat[ADDR_W-1:0] = s.cfgAddr;
					n.wbDat[CFG_TONLY]  = s.cfgTonly;
					if (wbWr) begin
						n.cfgAddr  = wbReq.dat[ADDR_W-1:0];
						n.cfgTonly = wbReq.dat[CFG_TONLY];
					end
				end
				REG_STATUS: begin
					n.wbDat[ST_REMOTE]         = s.remote;
					n.wbDat[ST_LOCKOUT]        = s.lockout;
					n.wbDat[ST_LISTEN]         = s.listen;
					n.wbDat[ST_TALK]           = s.talk;
					n.wbDat[ST_SPMODE]         = s.spMode;
					n.wbDat[ST_INERR]          = s.inErr;
					n.wbDat[ST_RQS]            = s.rqs;
					n.wbDat[ST_OUTFULL]        = (s.outCnt == PW'(DEPTH));
					n.wbDat[ST_INCNT +: PW]    = s.inCnt;
					n.wbDat[ST_OUTCNT +: PW]   = s.outCnt;
					errClr = wbWr && wbReq.dat[ST_INERR];
				end
				REG_STB: begin
					n.wbDat[7:0] = stbByte;
					if (wbWr) begin
						n.esb  = wbReq.dat[STB_ESB];
						n.dsb  = wbReq.dat[STB_DSB];
						rqsSet = wbReq.dat[STB_RQS];
					end
				end
				REG_INDATA: begin
					if (!wbReq.we && s.inCnt != '0) begin
						pr    = classify(s.inMem[s.inRd], s.pHdr, s.pDat, s.pSp);
						inPop = 1'b1;
						n.wbDat[7:0]             = s.inMem[s.inRd];
						n.wbDat[IND_CLS +: 4]    = pr.cls;
						n.wbDat[IND_VALID]       = 1'b1;
						n.pHdr = pr.hdr;
						n.pDat = pr.dat;
						n.pSp  = pr.sp;
					end
				end
				REG_OUTDATA: begin
					outPush = wbWr && (s.outCnt != PW'(DEPTH));
				end
				REG_PANEL: begin
					n.wbDat[PNL_LOCAL] = !s.remote && !s.lockout;
					n.wbDat[PNL_OTHER] = s.keyTaken;
					if (wbWr) begin
						if (wbReq.dat[PNL_LOCAL]) begin
							n.keyTaken = !s.lockout;
							if (s.remote && !s.lockout) begin
								n.remote = 1'b0;
							end
						end else if (wbReq.dat[PNL_OTHER]) begin
							n.keyTaken = !s.remote && !s.lockout;
						end
					end
				end
				default: begin
				end
			endcase
		end

		n.inErr = (s.inErr && !errClr) || errSet;
		n.rqs   = (s.rqs && !rqsClr) || rqsSet;
		n.bus.srq    = 1'b0;
		n.bus.srqOeN = !n.rqs;

		if (inPush) begin
			n.inMem[s.inWr] = rxByte;
			n.inWr = ptrInc(s.inWr);
		end
		if (inPop) begin
			n.inRd = ptrInc(s.inRd);
		end
		n.inCnt = cntStep(s.inCnt, inPush, inPop);
		if (outPush) begin
			n.outMem[s.outWr] = wbReq.dat[7:0];
			n.outWr = ptrInc(s.outWr);
		end
		if (outPop) begin
			n.outRd = ptrInc(s.outRd);
		end
		n.outCnt = cntStep(s.outCnt, outPush, outPop);

		// Device clear keeps settings and status; emptying the buffers drops MAV only.
		if (clearBufs) begin
			n.inWr     = '0;
			n.inRd     = '0;
			n.inCnt    = '0;
			n.outWr    = '0;
			n.outRd    = '0;
			n.outCnt   = '0;
			n.pHdr     = 1'b0;
			n.pDat     = 1'b0;
			n.pSp      = 1'b0;
			n.devClear = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s       <= '0;
			s.sync1 <= BUS_IN_IDLE;
			s.sync2 <= BUS_IN_IDLE;
			s.bus   <= BUS_OUT_IDLE;
			s.src   <= SRC_IDLE;
			s.acc   <= ACC_IDLE;
		end else begin
			s <= n;
		end
	end

	assign wbRsp    = '{ack: s.wbAck, dat: s.wbDat};
	assign busOut   = s.bus;
	assign trigger  = s.trigger;
	assign devClear = s.devClear;
endmodule : gdi_core

// File: test/gdi_monitor.sv
// Concurrent checks on the ports of the GPIB device interface core.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module gdi_monitor #(
	parameter int DEPTH = gdi_pkg::DEPTH
) (
	input wire logic                clock,
	input wire logic                reset,
	input wire gdi_pkg::gdi_wbReq_t  wbReq,
	input wire gdi_pkg::gdi_wbRsp_t  wbRsp,
	input wire gdi_pkg::gdi_busIn_t  busIn,
	input wire gdi_pkg::gdi_busOut_t busOut,
	input wire logic                trigger,
	input wire logic                devClear
);
	import gdi_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_taken; wbReq.cyc && wbReq.stb && !wbRsp.ack; endsequence
	sequence s_ifcHeld; (busIn.ifc == 1'b0) [*3]; endsequence
	sequence s_atnHeld; (busIn.atn == 1'b0) [*3]; endsequence
	property p_ackNext; s_taken |=> wbRsp.ack; endproperty
	a_ackNext: assert property (p_ackNext) else $error("request not acknowledged");
	property p_ackPulse; wbRsp.ack |=> !wbRsp.ack; endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
	property p_datIdle; !wbRsp.ack |-> wbRsp.dat == 32'h0; endproperty
	a_datIdle: assert property (p_datIdle) else $error("read data without ack");
	property p_ifcHalt;
		s_ifcHeld |=> busOut.davOeN && busOut.dioOeN && busOut.eoiOeN && busOut.nrfdOeN
			&& busOut.ndacOeN;
	endproperty
	a_ifcHalt: assert property (p_ifcHalt) else $error("transfer goes on under IFC");
	property p_atnWins; s_atnHeld |=> busOut.davOeN && busOut.dioOeN && busOut.eoiOeN; endproperty
	a_atnWins: assert property (p_atnWins) else $error("source active under ATN");
	property p_hsExcl; busOut.nrfdOeN || busOut.ndacOeN; endproperty
	a_hsExcl: assert property (p_hsExcl) else $error("NRFD and NDAC both held");
	property p_davData; !busOut.davOeN |-> !busOut.dioOeN; endproperty
	a_davData: assert property (p_davData) else $error("DAV driven without data");
	property p_dioHold;
		(!busOut.davOeN && !busOut.dav) |=> busOut.davOeN || busOut.dav || $stable(busOut.dio);
	endproperty
	a_dioHold: assert property (p_dioHold) else $error("data moved while valid");
	property p_clrPulse; devClear |=> !devClear; endproperty
	a_clrPulse: assert property (p_clrPulse) else $error("clear pulse too long");
	property p_trigPulse; trigger |=> !trigger; endproperty
	a_trigPulse: assert property (p_trigPulse) else $error("trigger pulse too long");
endmodule : gdi_monitor

bind gdi_core gdi_monitor #(.DEPTH(DEPTH)) u_mon (.clock(clock), .reset(reset), .wbReq(wbReq),
	.wbRsp(wbRsp), .busIn(busIn), .busOut(busOut), .trigger(trigger), .devClear(devClear));

// File: test/gdi_ctl_model.sv
// Behavioural active controller on the far side of the GPIB lines.
// Assumes the caller runs one task at a time; released lines read high.
`timescale 1ns/1ns
module gdi_ctl_model (
	input  wire logic                clock,
	input  wire gdi_pkg::gdi_busOut_t busOut,
	output gdi_pkg::gdi_busIn_t      busIn
);
	import gdi_pkg::*;
	logic [7:0] dioC = 8'hFF;
	logic       davC = 1'b1;
	logic       nrfdC = 1'b1;
	logic       ndacC = 1'b1;
	logic       atnC = 1'b1;
	logic       ifcC = 1'b1;
	logic       renC = 1'b1;
	logic       eoiSeen = 1'b0;
	assign busIn = '{dio: dioC & (busOut.dioOeN ? 8'hFF : busOut.dio),
		dav: davC & (busOut.davOeN | busOut.dav), nrfd: nrfdC & (busOut.nrfdOeN | busOut.nrfd),
		ndac: ndacC & (busOut.ndacOeN | busOut.ndac), eoi: busOut.eoiOeN | busOut.eoi,
		atn: atnC, ifc: ifcC, ren: renC};
	task automatic send(input logic atn, input logic [7:0] b);
		@(posedge clock);
		atnC <= ~atn;
		nrfdC <= 1'b1;
		ndacC <= 1'b1;
		do @(posedge clock); while (!(busIn.nrfd && !busIn.ndac));
		dioC <= ~b;
		@(posedge clock);
		davC <= 1'b0;
		do @(posedge clock); while (!busIn.ndac);
		davC <= 1'b1;
		dioC <= 8'hFF;
		// One more edge lets the registered pulses of this byte reach the bench counters.
		@(posedge clock);
	endtask : send
	task automatic take(output logic [7:0] b);
		@(posedge clock);
		atnC <= 1'b1;
		nrfdC <= 1'b1;
		ndacC <= 1'b0;
		do @(posedge clock); while (busIn.dav);
		b = ~busIn.dio;
		eoiSeen = !busIn.eoi;
		nrfdC <= 1'b0;
		ndacC <= 1'b1;
		do @(posedge clock); while (!busIn.dav);
		ndacC <= 1'b0;
	endtask : take
	task automatic hold();
		@(posedge clock);
		atnC <= 1'b1;
		nrfdC <= 1'b0;
		ndacC <= 1'b0;
	endtask : hold
	task automatic lines(input logic atn, input logic ifc, input logic ren);
		@(posedge clock);
		atnC <= ~atn;
		ifcC <= ~ifc;
		renC <= ~ren;
	endtask : lines
endmodule : gdi_ctl_model

// File: test/gpib_device_interface_test.sv
// Self-checking bench for the GPIB device interface core.
// Assumes the controller model drives the bus and the bench owns Wishbone.
`timescale 1ns/1ns
module gpib_device_interface_test;
	import gdi_pkg::*;
	logic        clock;
	logic        reset;
	gdi_wbReq_t  wbReq;
	gdi_wbRsp_t  wbRsp;
	gdi_busIn_t  busIn;
	gdi_busOut_t busOut;
	logic        trigger;
	logic        devClear;
	int          n_errors = 0;
	int          checks_done = 0;
	int          nClr = 0;
	int          nTrig = 0;
	int          cycles = 0;
	logic [31:0] q;
	logic [7:0]  b;
	gdi_core #(.DEPTH(8)) u_dut (.clock(clock), .reset(reset), .wbReq(wbReq), .wbRsp(wbRsp),
		.busIn(busIn), .busOut(busOut), .trigger(trigger), .devClear(devClear));
	gdi_ctl_model u_ctl (.clock(clock), .busOut(busOut), .busIn(busIn));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (devClear === 1'b1) nClr++;
		if (trigger === 1'b1) nTrig++;
		if (cycles == 60000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: d};
		do @(posedge clock); while (wbRsp.ack !== 1'b1);
		q = wbRsp.dat;
		wbReq <= '0;
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rdChk
	task automatic t_remote();
		rdChk(REG_CONFIG, 32'h3F, 32'h0);
		rdChk(8'h3C, 32'hFFFFFFFF, 32'h0);
		wr(REG_CONFIG, 32'h5);
		rdChk(REG_CONFIG, 32'h3F, 32'h5);
		u_ctl.lines(1'b0, 1'b0, 1'b1);
		u_ctl.send(1'b1, 8'h26);
		rdChk(REG_STATUS, 32'h4, 32'h0);
		u_ctl.send(1'b1, 8'h25);
		rdChk(REG_STATUS, 32'h7, 32'h5);
		wr(REG_PANEL, 32'h2);
		rdChk(REG_PANEL, 32'h3, 32'h0);
		u_ctl.send(1'b1, {1'b0, CMD_LLO});
		wr(REG_PANEL, 32'h1);
		rdChk(REG_STATUS, 32'h3, 32'h3);
		u_ctl.send(1'b1, {1'b0, CMD_GTL});
		rdChk(REG_STATUS, 32'h3, 32'h0);
		wr(REG_PANEL, 32'h2);
		rdChk(REG_PANEL, 32'h3, 32'h3);
	endtask : t_remote
	task automatic t_input();
		logic [7:0] s [8];
		logic [3:0] c [8];
		s = '{8'h2A, 8'h41, 8'h3F, 8'h20, 8'h31, 8'h2C, 8'h32, 8'h3B};
		c = '{CLS_COMMON, CLS_HDR, CLS_QUERY, CLS_SPACE, CLS_DATA, CLS_ITEMSEP, CLS_DATA,
			CLS_CMDSEP};
		u_ctl.lines(1'b0, 1'b0, 1'b0);
		u_ctl.lines(1'b0, 1'b0, 1'b1);
		u_ctl.send(1'b1, 8'h25);
		for (int k = 0; k < 9; k++) u_ctl.send(1'b0, k < 8 ? s[k] : 8'h42);
		rdChk(REG_STATUS, 32'hFF20, 32'h0820);
		for (int k = 0; k < 8; k++)
			rdChk(REG_INDATA, 32'h10FFF, {15'h0, 1'b1, 4'h0, c[k], s[k]});
		rdChk(REG_INDATA, 32'h10000, 32'h0);
		u_ctl.send(1'b0, 8'h41);
		u_ctl.send(1'b1, {1'b0, CMD_DCL});
		rdChk(REG_STATUS, 32'hFF20, 32'h0020);
		chk(nClr, 1);
		u_ctl.send(1'b1, {1'b0, CMD_UNL});
		u_ctl.send(1'b1, {1'b0, CMD_SDC});
		chk(nClr, 1);
		u_ctl.send(1'b1, 8'h25);
		u_ctl.send(1'b1, {1'b0, CMD_SDC});
		chk(nClr, 2);
		u_ctl.send(1'b1, {1'b0, CMD_GET});
		chk(nTrig, 1);
		u_ctl.send(1'b1, 8'h15);
		rdChk(REG_STATUS, 32'hFF1F, 32'h0005);
		chk(nClr, 2);
		u_ctl.send(1'b1, {1'b0, CMD_GTL});
		u_ctl.send(1'b0, 8'h41);
		rdChk(REG_STATUS, 32'hFF01, 32'h0);
	endtask : t_input
	task automatic t_talk();
		wr(REG_OUTDATA, 32'h58);
		wr(REG_OUTDATA, 32'h59);
		rdChk(REG_STB, 32'h50, 32'h10);
		wr(REG_STB, 32'h40);
		rdChk(REG_STB, 32'h40, 32'h40);
		chk({31'h0, busOut.srqOeN}, 32'h0);
		u_ctl.send(1'b1, {1'b0, CMD_SPE});
		u_ctl.send(1'b1, 8'h45);
		u_ctl.take(b);
		chk({24'h0, b}, 32'h50);
		rdChk(REG_STB, 32'h40, 32'h0);
		u_ctl.send(1'b1, {1'b0, CMD_SPD});
		u_ctl.take(b);
		chk({24'h0, b}, 32'h58);
		chk({31'h0, u_ctl.eoiSeen}, 32'h0);
		u_ctl.take(b);
		chk({24'h0, b}, 32'h59);
		chk({31'h0, u_ctl.eoiSeen}, 32'h1);
		rdChk(REG_STB, 32'h10, 32'h0);
	endtask : t_talk
	task automatic t_abort();
		wr(REG_OUTDATA, 32'h5A);
		u_ctl.send(1'b1, 8'h45);
		u_ctl.hold();
		repeat (8) @(posedge clock);
		chk({31'h0, busOut.davOeN}, 32'h0);
		u_ctl.lines(1'b0, 1'b1, 1'b1);
		repeat (6) @(posedge clock);
		chk({31'h0, busOut.davOeN}, 32'h1);
		u_ctl.lines(1'b0, 1'b0, 1'b1);
		rdChk(REG_STATUS, 32'hFF0000, 32'h010000);
		u_ctl.send(1'b1, 8'h45);
		u_ctl.hold();
		repeat (8) @(posedge clock);
		u_ctl.lines(1'b1, 1'b0, 1'b1);
		repeat (6) @(posedge clock);
		chk({31'h0, busOut.davOeN}, 32'h1);
		rdChk(REG_STATUS, 32'hFF0000, 32'h010000);
		u_ctl.send(1'b1, {1'b0, CMD_DCL});
		rdChk(REG_STATUS, 32'hFF0000, 32'h0);
		rdChk(REG_STB, 32'h10, 32'h0);
	endtask : t_abort
	initial begin
		reset = 1'b1;
		wbReq = '0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_remote();
		t_input();
		t_talk();
		t_abort();
		wrap_up();
	end
endmodule : gpib_device_interface_test
